//--- tb/image_src.sv
// User-side model that streams image words
`timescale 1ns/1ps
module image_src
	import reconfig_loader_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   go,
	input  wire logic   wordReady,
	output logic        writeAll,
	output image_word_s wordIn
);
	initial begin
		writeAll = 1'b0;
		wordIn = 16'h0000;
	end
	// Idle data is inverted each cycle so a stale word never looks valid
	always @(posedge clk) begin
		writeAll <= go && wordReady;
		if (go && wordReady)
			wordIn <= 16'($urandom);
		else
			wordIn <= ~wordIn;
	end
endmodule : image_src

//--- tb/loader_chk.sv
// Port checker for the channel reconfiguration word loader
`timescale 1ns/1ps
`include "reconfig_loader_map.svh"
module loader_chk
	import reconfig_loader_pkg::*;
#(
	parameter logic [5:0] PTR_LAST = `PTR_LAST_DEF
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic [2:0]  modeSel,
	input wire logic        writeAll,
	input wire image_word_s wordIn,
	input wire logic        ptrClear,
	input wire logic        wordReady,
	input wire logic [5:0]  wordPtr,
	input wire logic        ptrChanged,
	input wire logic        reconfigDone,
	input wire logic        ocBusy,
	input wire chan_write_s chanWrite
);
	logic ocDone = 1'b0;
	// Power-up only, so a later rst leaves it set
	always_ff @(posedge clk) begin
		if (!rst && $fell(ocBusy) && !$past(rst))
			ocDone <= 1'b1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_step;
		ptrChanged && !$past(ptrClear) |-> wordPtr ==
			(($past(wordPtr) == PTR_LAST) ? 6'h00 : $past(wordPtr) + 6'h01);
	endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_chg;
		$changed(wordPtr) |-> ptrChanged || wordPtr == 6'h00;
	endproperty
	a_chg: assert property (p_chg) else $error("silent change");
	property p_after;
		ptrChanged |-> $past(chanWrite.wrEn, 2) || $past(chanWrite.wrEn, 3);
	endproperty
	a_after: assert property (p_after) else $error("early flag");
	property p_done;
		ptrChanged && wordPtr == 6'h00 |-> reconfigDone;
	endproperty
	a_done: assert property (p_done) else $error("no done");
	property p_undone;
		ptrChanged && wordPtr == 6'h01 |-> !reconfigDone;
	endproperty
	a_undone: assert property (p_undone) else $error("done stuck");
	property p_addr;
		chanWrite.wrEn |-> chanWrite.addr == wordPtr;
	endproperty
	a_addr: assert property (p_addr) else $error("bad addr");
	property p_space;
		chanWrite.wrEn |=> !chanWrite.wrEn [*3];
	endproperty
	a_space: assert property (p_space) else $error("too close");
	property p_rst;
		$fell(rst) |-> wordPtr == 6'h00 && !reconfigDone && !chanWrite.wrEn;
	endproperty
	a_rst: assert property (p_rst) else $error("not reset");
	property p_once;
		ocDone |-> !ocBusy && !(ocBusy && wordReady);
	endproperty
	a_once: assert property (p_once) else $error("rerun");
endmodule : loader_chk

//--- tb/testbench.sv
// Self-checking bench for the word loader
`timescale 1ns/1ps
`define CHK(a, b) tests_run++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t value mismatch", $time); end
module testbench
	import reconfig_loader_pkg::*;
;
	localparam logic [5:0] PL = 6'h03;
	logic clk = 1'b0, rst = 1'b1, ptrClear = 1'b0, go = 1'b0, ce = 1'b1;
	logic [2:0] modeSel = 3'h1;
	logic writeAll, wordReady, ptrChanged, reconfigDone, ocBusy;
	logic [5:0] wordPtr;
	logic [5:0] ptrExp = 6'h00;
	logic [21:0] expQ[$];
	logic [21:0] e;
	image_word_s wordIn;
	chan_write_s chanWrite;
	int failures = 0, tests_run = 0, n;
	initial forever #2.5 clk = ~clk;
	// ce is dropped once while idle to show that state freezes
	channel_reconfig_word_loader #(.PTR_LAST(PL))
	channel_reconfig_word_loader_i (.clk(clk), .rst(rst), .ce(ce),
		.modeSel(modeSel), .writeAll(writeAll), .wordIn(wordIn),
		.ptrClear(ptrClear), .wordReady(wordReady), .wordPtr(wordPtr),
		.ptrChanged(ptrChanged), .reconfigDone(reconfigDone),
		.ocBusy(ocBusy), .chanWrite(chanWrite));
	image_src image_src_i (.clk(clk), .go(go), .wordReady(wordReady),
		.writeAll(writeAll), .wordIn(wordIn));
	task close_out;
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	// Note each accepted word with the address it must land at
	always @(posedge clk) begin
		if (writeAll === 1'b1 && modeSel == 3'h1 && !rst && ce
		    && !ptrClear) begin
			expQ.push_back({ptrExp, wordIn.data});
			ptrExp = (ptrExp == PL) ? 6'h00 : ptrExp + 6'h01;
		end
	end
	always @(posedge clk) begin
		if (chanWrite.wrEn === 1'b1) begin
			if (expQ.size() == 0) begin
				`CHK(1'b0, 1'b1)
			end else begin
				e = expQ.pop_front();
				`CHK(chanWrite.addr, e[21:16])
				`CHK(chanWrite.data, e[15:0])
			end
		end
		if (ptrChanged === 1'b1) begin
			`CHK(reconfigDone, wordPtr == 6'h00)
		end
	end
	task busy_count(input int c);
		n = 0;
		repeat (c) begin
			@(posedge clk);
			n += int'(ocBusy === 1'b1);
		end
	endtask : busy_count
	task pump(input int c);
		@(posedge clk);
		go <= 1'b1;
		repeat (c) @(posedge clk);
		go <= 1'b0;
		repeat (100) @(posedge clk);
		`CHK(expQ.size(), 0)
	endtask : pump
	initial begin
		#20000;
		failures++;
		close_out();
	end
	initial begin
		void'($urandom(32'h6978));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		busy_count(40);
		`CHK(n, 16)
		// Burst long enough to fill the buffer up to its credit limit
		pump(40);
		@(posedge clk);
		modeSel <= 3'h0;
		pump(10);
		modeSel <= 3'h1;
		@(posedge clk);
		go <= 1'b1;
		for (int i = 0; i < 200 && (i < 8 || ptrExp != 6'h02); i++)
			@(posedge clk);
		go <= 1'b0;
		repeat (60) @(posedge clk);
		// A frozen block ignores the clear and keeps its pointer
		ce <= 1'b0;
		@(posedge clk);
		ptrClear <= 1'b1;
		@(posedge clk);
		ptrClear <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		`CHK(wordPtr, ptrExp)
		@(posedge clk);
		ptrClear <= 1'b1;
		@(posedge clk);
		ptrClear <= 1'b0;
		expQ.delete();
		ptrExp = 6'h00;
		repeat (5) @(posedge clk);
		`CHK(wordPtr, 6'h00)
		pump(3);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		ptrExp = 6'h00;
		`CHK(wordPtr, 6'h00)
		busy_count(30);
		`CHK(n, 0)
		pump(6);
		close_out();
	end
endmodule : testbench
bind channel_reconfig_word_loader loader_chk #(.PTR_LAST(PTR_LAST))
	loader_chk_i (.clk(clk), .rst(rst), .ce(ce), .modeSel(modeSel),
	.writeAll(writeAll), .wordIn(wordIn), .ptrClear(ptrClear),
	.wordReady(wordReady), .wordPtr(wordPtr), .ptrChanged(ptrChanged),
	.reconfigDone(reconfigDone), .ocBusy(ocBusy), .chanWrite(chanWrite));

//--- verilog/channel_reconfig_word_loader.sv
// Channel reconfiguration word loader, top level
//
// Notes on behaviour
// [R01] Mode code 000 selects analog controls (default), 001 channel reconfig.
// [R02] Mode select exists only when more than one mode is built in.
// [R03] Six-bit pointer steps by one per word, wraps to 0 at end.
// [R04] Pointer-changed pulse only after a full 16-bit word is written.
// [R05] One-cycle pointer-clear pulse resets the word pointer.
// [R06] User presents a 16-bit word with every write strobe.
// [R07] Loader reset clears all registers and aborts reconfiguration; here offset cancellation stays done through it; a run in progress restarts.
// [R08] User synchronises the loader reset to this clock.
// [R09] Completion output rises once all image words are written.
// [R10] Completion clears at the start of a new write sequence.
// [R11] Offset cancellation runs once after power up only.
// [R12] Reset during cancellation leaves it pending until reset drops.
// [R13] New strobe accepted only once the previous word is written; here strobes queue in the word buffer and are written one at a time.
`timescale 1ns/1ps
`include "reconfig_loader_map.svh"
module channel_reconfig_word_loader
	import reconfig_loader_pkg::*;
#(
	parameter bit         MULTI_MODE = 1'b1,
	parameter logic [5:0] PTR_LAST   = `PTR_LAST_DEF,
	parameter int         FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [2:0]  modeSel,
	input  wire logic        writeAll,
	input  wire image_word_s wordIn,
	input  wire logic        ptrClear,
	output logic             wordReady,
	output logic [5:0]       wordPtr,
	output logic             ptrChanged,
	output logic             reconfigDone,
	output logic             ocBusy,
	output chan_write_s      chanWrite
);
	// ==========================================================
	// Parameter checks
	// occupancy reaches the strobe through three flops here and one in the
	// user logic, so this many slots are held back as credit
	localparam int LAG   = `STROBE_LAG;
	localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;

	if (PTR_LAST == `PTR_ZERO) begin : g_bad_last
		$error("loader: PTR_LAST must be above zero");
	end

	if (FIFO_DEPTH <= LAG) begin : g_bad_depth
		$error("loader: FIFO_DEPTH must exceed the strobe lag");
	end

	if ((1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_pow
		$error("loader: FIFO_DEPTH must be a power of two");
	end

	// ==========================================================
	// Mode decode
	mode_e       mode;
	logic        chanMode;
	assign mode     = MULTI_MODE ? mode_e'(modeSel) : MODE_CHANNEL_E; // [R02]
	assign chanMode = (mode == MODE_CHANNEL_E); // [R01]

	// ==========================================================
	// Word buffer; rst is assumed already synchronous to clk
	logic        fifoInReady;
	logic        fifoOutValid;
	logic        fifoOutReady;
	logic [15:0] fifoOutData;
	logic        ocBusyW;
	logic        ocDoneW;
	load_state_e state_reg;
	logic [3:0]  wrCnt_reg;
	logic [5:0]  ptr_reg;
	logic [15:0] word_reg;
	logic        seqActive_reg;
	logic        changed_reg;
	logic        done_reg;
	logic        ready_reg;
	logic        wrEn_reg;
	logic        flushW;

	// A clear is ignored while frozen, like every state change except reset outside the offset cancellation sequencer
	assign flushW = rst || (ce && ptrClear); // [R05]

	word_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (flushW), // [R07]
		.ce       (ce),
		.inValid  (writeAll && chanMode), // [R06]
		.inReady  (fifoInReady),
		.inData   (wordIn.data),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	offset_cancel_seq u_oc (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.busy (ocBusyW),
		.done (ocDoneW)
	);

	// Words drain only when idle, so a queued word never overtakes one
	// still being written into the channel.
	assign fifoOutReady = (state_reg == LD_IDLE) && ocDoneW && !ptrClear; // [R13]

	// ==========================================================
	// Buffer occupancy
	// Mirrors the buffer's own pointers; a full flag alone would be seen
	// too late by a user that strobes on every ready cycle.
	logic [OCC_W-1:0] occ_reg;
	logic             pushW;
	logic             popW;

	assign pushW = ce && writeAll && chanMode && fifoInReady;
	assign popW  = ce && fifoOutValid && fifoOutReady;

	always_ff @(posedge clk) begin
		if (flushW)
			occ_reg <= '0; // [R05]
		else if (pushW && !popW)
			occ_reg <= occ_reg + 1'b1;
		else if (popW && !pushW)
			occ_reg <= occ_reg - 1'b1;
	end

	// ==========================================================
	// Write sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= LD_IDLE; // [R07]
		end else if (ce) begin
			case (state_reg)
				LD_IDLE: begin
					if (fifoOutValid && fifoOutReady)
						state_reg <= LD_WRITE;
				end
				LD_WRITE: begin
					if (ptrClear)
						state_reg <= LD_IDLE;
					else if (wrCnt_reg == `WORD_WRITE_CYC - 4'h1)
						state_reg <= LD_STEP;
				end
				LD_STEP: state_reg <= LD_IDLE;
				default: state_reg <= LD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			wrCnt_reg <= 4'h0;
		else if (ce) begin
			if (state_reg == LD_WRITE)
				wrCnt_reg <= wrCnt_reg + 4'h1;
			else
				wrCnt_reg <= 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			word_reg <= 16'h0000;
		else if (ce && state_reg == LD_IDLE && fifoOutValid && fifoOutReady)
			word_reg <= fifoOutData;
	end

	// ==========================================================
	// Word pointer
	always_ff @(posedge clk) begin
		if (rst)
			ptr_reg <= `PTR_ZERO;
		else if (ce) begin
			if (ptrClear)
				ptr_reg <= `PTR_ZERO; // [R05]
			else if (state_reg == LD_STEP) begin
				if (ptr_reg == PTR_LAST)
					ptr_reg <= `PTR_ZERO; // [R03]
				else
					ptr_reg <= ptr_reg + `PTR_STEP; // [R03]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			changed_reg <= 1'b0;
		else if (ce)
			changed_reg <= (state_reg == LD_STEP) && !ptrClear; // [R04]
	end

	// ==========================================================
	// Completion flag
	always_ff @(posedge clk) begin
		if (rst)
			seqActive_reg <= 1'b0;
		else if (ce) begin
			if (ptrClear)
				seqActive_reg <= 1'b0;
			else if (state_reg == LD_IDLE && fifoOutValid && fifoOutReady)
				seqActive_reg <= 1'b1;
			else if (state_reg == LD_STEP && ptr_reg == PTR_LAST)
				seqActive_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			done_reg <= 1'b0;
		else if (ce) begin
			if (state_reg == LD_STEP && ptr_reg == PTR_LAST && !ptrClear)
				done_reg <= 1'b1; // [R09]
			else if (!seqActive_reg && state_reg == LD_IDLE
			         && fifoOutValid && fifoOutReady)
				done_reg <= 1'b0; // [R10]
		end
	end

	// ==========================================================
	// Channel write port and status outputs, all registered
	always_ff @(posedge clk) begin
		if (rst)
			wrEn_reg <= 1'b0;
		else if (ce)
			wrEn_reg <= (state_reg == LD_IDLE) && fifoOutValid && fifoOutReady;
	end

	always_ff @(posedge clk) begin
		if (rst)
			ready_reg <= 1'b0;
		else if (ce)
			ready_reg <= (occ_reg <= OCC_W'(FIFO_DEPTH - LAG))
			             && chanMode && ocDoneW; // [R13]
	end

	always_ff @(posedge clk) begin
		if (rst)
			chanWrite.wrEn <= 1'b0;
		else if (ce)
			chanWrite.wrEn <= wrEn_reg;
	end

	always_ff @(posedge clk) begin
		if (rst)
			chanWrite.addr <= `PTR_ZERO;
		else if (ce)
			chanWrite.addr <= ptr_reg; // [R03]
	end

	always_ff @(posedge clk) begin
		if (rst)
			chanWrite.data <= 16'h0000;
		else if (ce)
			chanWrite.data <= word_reg;
	end

	// ==========================================================
	// Status outputs
	always_ff @(posedge clk) begin
		if (rst)
			wordPtr <= `PTR_ZERO;
		else if (ce)
			wordPtr <= ptr_reg;
	end

	always_ff @(posedge clk) begin
		if (rst)
			ptrChanged <= 1'b0;
		else if (ce)
			ptrChanged <= changed_reg; // [R04]
	end

	always_ff @(posedge clk) begin
		if (rst)
			reconfigDone <= 1'b0;
		else if (ce)
			reconfigDone <= done_reg; // [R09]
	end

	always_ff @(posedge clk) begin
		if (rst)
			wordReady <= 1'b0;
		else if (ce)
			wordReady <= ready_reg;
	end

	always_ff @(posedge clk) begin
		if (rst)
			ocBusy <= 1'b0;
		else if (ce)
			ocBusy <= ocBusyW;
	end
endmodule : channel_reconfig_word_loader

//--- verilog/offset_cancel_seq.sv
// Power-up offset cancellation sequencer
`timescale 1ns/1ps
`include "reconfig_loader_map.svh"
module offset_cancel_seq
	import reconfig_loader_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	output logic      busy,
	output logic      done
);
	// ==========================================================
	// Sequence state; the done state is left only by power cycle
	oc_state_e   state_reg   = OC_WAIT;
	logic [4:0]  count_reg   = 5'h00;
	logic        powered_reg = 1'b0;
	assign busy = state_reg == OC_RUN;
	assign done = state_reg == OC_DONE;
	always_ff @(posedge clk) begin
		if (ce)
			powered_reg <= 1'b1;
	end
	always_ff @(posedge clk) begin
		if (ce) begin
			case (state_reg)
				OC_WAIT: begin
					if (!rst && powered_reg)
						state_reg <= OC_RUN;
				end
				OC_RUN: begin
					if (rst)
						state_reg <= OC_WAIT; // [R12]
					else if (count_reg == `OC_CYCLES - 5'h01)
						state_reg <= OC_DONE;
				end
				OC_DONE: state_reg <= OC_DONE; // [R11]
				default: state_reg <= OC_WAIT;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (ce) begin
			if (state_reg != OC_RUN || rst)
				count_reg <= 5'h00;
			else
				count_reg <= count_reg + 5'h01;
		end
	end
endmodule : offset_cancel_seq

//--- verilog/reconfig_loader_map.svh
// Constants for the channel reconfiguration word loader
`ifndef RECONFIG_LOADER_MAP_SVH
`define RECONFIG_LOADER_MAP_SVH
`define MODE_ANALOG      3'h0
`define MODE_CHANNEL     3'h1
`define PTR_ZERO         6'h00
`define PTR_STEP         6'h01
`define PTR_LAST_DEF     6'h3f
`define WORD_WRITE_CYC   4'h2
`define OC_CYCLES        5'h10
`define FIFO_DEPTH_DEF   16
`define STROBE_LAG       4
`endif

//--- verilog/reconfig_loader_pkg.sv
// Types shared by the channel reconfiguration word loader
package reconfig_loader_pkg;
	typedef enum logic [2:0] {
		MODE_ANALOG_E  = 3'h0,
		MODE_CHANNEL_E = 3'h1
	} mode_e;
	typedef struct packed {
		logic [15:0] data;
	} image_word_s;
	typedef struct packed {
		logic        wrEn;
		logic [5:0]  addr;
		logic [15:0] data;
	} chan_write_s;
	typedef enum logic [1:0] {
		OC_WAIT = 2'b00,
		OC_RUN  = 2'b01,
		OC_DONE = 2'b11
	} oc_state_e;
	typedef enum logic [1:0] {
		LD_IDLE  = 2'b00,
		LD_WRITE = 2'b01,
		LD_STEP  = 2'b11
	} load_state_e;
endpackage : reconfig_loader_pkg

//--- verilog/word_fifo.sv
// Synchronous FIFO for image words
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("word_fifo: DEPTH must be a power of two >= 2");
	end
	// ==========================================================
	// Storage and pointers
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_reg;
	logic [AW:0]      rdPtr_reg;
	logic             doWr;
	logic             doRd;
	assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
	assign outValid = wrPtr_reg != rdPtr_reg;
	assign outData  = mem[rdPtr_reg[AW-1:0]];
	assign doWr     = ce && inValid && inReady;
	assign doRd     = ce && outValid && outReady;
	always_ff @(posedge clk) begin
		if (doWr)
			mem[wrPtr_reg[AW-1:0]] <= inData;
	end
	always_ff @(posedge clk) begin
		if (rst)
			wrPtr_reg <= '0;
		else if (doWr)
			wrPtr_reg <= wrPtr_reg + 1'b1;
	end
	always_ff @(posedge clk) begin
		if (rst)
			rdPtr_reg <= '0;
		else if (doRd)
			rdPtr_reg <= rdPtr_reg + 1'b1;
	end
endmodule : word_fifo
